// file: hdl/oss_startup_seq.sv
// Output start-up sequencer with power-good and start-up timeout handling
`timescale 1ns/100ps
module oss_startup_seq #(
   parameter int MS_CYC = oss_pkg::OSS_MS_CYC
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Command port
   input  wire oss_pkg::oss_cmd_t     cmd,
   output logic [15:0]                cmd_rdata,
   output logic                       cmd_ack,
   output logic                       cmd_nack,
   // On/off sources
   input  wire logic                  ctrl_pin,
   input  wire logic                  bias_ok_pin,
   input  wire logic                  op_on,
   input  wire logic                  other_fault,
   input  wire logic                  fault_clear,
   // Measurement and shared settings
   input  wire logic [15:0]           vout_meas,
   input  wire logic [15:0]           uv_fault_limit,
   input  wire logic [7:0]            vout_fault_unit_ms,
   // Outputs
   output logic                       power_good_output,
   output logic                       output_enable,
   output logic                       ramp_active,
   output logic                       startup_fault,
   output logic [2:0]                 retry_count,
   output oss_pkg::oss_state_t        seq_state
);
   import oss_pkg::*;

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   typedef struct packed {
      oss_cfg_t    cfg;
      oss_state_t  st;
      logic [2:0]  tries;
      logic        tmo_arm;
      logic        fault;
      logic        pg;
      logic        out_en;
      logic        ramp;
      logic [15:0] rdata;
      logic        ack;
      logic        nack;
      logic [1:0]  pin_meta;
      logic [1:0]  pin_sync;
   } oss_core_t;

   localparam oss_cfg_t CFG_RST = '{
      pg_on:   OSS_RST_PG_ON,
      pg_off:  OSS_RST_PG_OFF,
      dly:     OSS_RST_DELAY,
      ramp:    OSS_RST_RAMP,
      tmo_lim: OSS_RST_TMO_LIM,
      rsp:     OSS_RST_TMO_RSP
   };

   oss_core_t              r;
   oss_core_t              nxt;
   logic [OSS_NUM_TMR-1:0] tmr_start;
   logic [OSS_TMR_W-1:0]   tmr_load [OSS_NUM_TMR];
   logic [OSS_NUM_TMR-1:0] tmr_exp;
   logic                   run_ok;
   logic                   reached;
   logic                   tmo_event;
   logic                   launch;
   logic [1:0]             rsp_code;
   logic [2:0]             rty_code;
   logic [OSS_TMR_W-1:0]   unit_ticks;

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   // Linear format: 5-bit signed exponent, 11-bit mantissa, in ms
   function automatic logic [OSS_TMR_W-1:0] lin_ticks(
      input logic [15:0] v
   );
      logic signed [5:0] sh;
      logic [5:0]        rsh;
      logic [34:0]       wide;
      sh   = $signed({v[OSS_LIN_EXP_HI], v[OSS_LIN_EXP_HI:OSS_LIN_EXP_LO]})
             + $signed({2'b00, OSS_TICK_SHIFT});
      rsh  = 6'(-sh);
      wide = {24'h000000, v[OSS_LIN_MANT_HI:0]};
      if (sh >= 0) begin
         wide = wide << sh[4:0];
      end else begin
         wide = wide >> rsh;
      end
      // Saturate rather than wrap on huge settings
      return (|wide[34:OSS_TMR_W]) ? '1 : wide[OSS_TMR_W-1:0];
   endfunction : lin_ticks

   function automatic oss_state_t retry_next(
      input logic [2:0] rty,
      input logic [2:0] tries
   );
      if (rty == OSS_RTY_NONE) begin
         return OSS_LATCH;
      end else if (rty == OSS_RTY_FOREVER || tries < rty) begin
         return OSS_RWAIT;
      end else begin
         return OSS_LATCH;
      end
   endfunction : retry_next

   assign rsp_code   = r.cfg.rsp[OSS_RSP_HI:OSS_RSP_LO];
   assign rty_code   = r.cfg.rsp[OSS_RTY_HI:OSS_RTY_LO];
   // Two to the field value of the voltage fault unit, in ticks
   assign unit_ticks = OSS_TMR_W'({16'h0000, vout_fault_unit_ms}
                       << ({1'b0, r.cfg.rsp[OSS_TIME_HI:OSS_TIME_LO]}
                           + OSS_TICK_SHIFT));

   assign run_ok  = r.pin_sync[1] & r.pin_sync[0] & op_on & ~other_fault;
   assign reached = (vout_meas >= uv_fault_limit);
   assign tmo_event = r.tmo_arm & tmr_exp[OSS_T_TMO] & ~reached & run_ok
                      & (r.st == OSS_DELAY || r.st == OSS_RISE
                         || r.st == OSS_ON);

   // --------------------------------------------------------------
   // Timers
   // --------------------------------------------------------------
   for (genvar g = 0; g < OSS_NUM_TMR; g++) begin : g_tmr
      oss_tick_timer #(
         .TICK_DIV (MS_CYC / OSS_TICKS_PER_MS)
      ) u_tmr (
         .clk     (clk),
         .rst_n   (rst_n),
         .start   (tmr_start[g]),
         .load    (tmr_load[g]),
         .expired (tmr_exp[g])
      );
   end

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb begin
      nxt       = r;
      tmr_start = '0;
      launch    = 1'b0;
      for (int i = 0; i < OSS_NUM_TMR; i++) begin
         tmr_load[i] = '0;
      end
      nxt.pin_meta = {ctrl_pin, bias_ok_pin};
      nxt.pin_sync = r.pin_meta;
      nxt.ack      = 1'b0;
      nxt.nack     = 1'b0;

      // Command decode
      if (cmd.wr || cmd.rd) begin
         nxt.ack = 1'b1;
         case (cmd.code)
            OSS_CMD_PG_ON:   nxt.rdata = r.cfg.pg_on;
            OSS_CMD_PG_OFF:  nxt.rdata = r.cfg.pg_off;
            OSS_CMD_DELAY:   nxt.rdata = r.cfg.dly;
            OSS_CMD_RAMP:    nxt.rdata = r.cfg.ramp;
            OSS_CMD_TMO_LIM: nxt.rdata = r.cfg.tmo_lim;
            OSS_CMD_TMO_RSP: nxt.rdata = {8'h00, r.cfg.rsp};
            default: begin
               nxt.rdata = 16'h0000;
               nxt.ack   = 1'b0;
               nxt.nack  = 1'b1;
            end
         endcase
         if (cmd.wr) begin
            case (cmd.code)
               OSS_CMD_PG_ON:   nxt.cfg.pg_on   = cmd.wdata;
               OSS_CMD_PG_OFF:  nxt.cfg.pg_off  = cmd.wdata;
               OSS_CMD_DELAY:   nxt.cfg.dly     = cmd.wdata;
               OSS_CMD_RAMP:    nxt.cfg.ramp    = cmd.wdata;
               OSS_CMD_TMO_LIM: nxt.cfg.tmo_lim = cmd.wdata;
               OSS_CMD_TMO_RSP: nxt.cfg.rsp     = cmd.wdata[7:0];
               default:         nxt.cfg         = r.cfg;
            endcase
         end
      end

      // Power-good with hysteresis; deassert wins on overlap
      if (vout_meas <= r.cfg.pg_off) begin
         nxt.pg = 1'b0;
      end else if (vout_meas >= r.cfg.pg_on) begin
         nxt.pg = 1'b1;
      end

      // Set wins over clear
      nxt.fault = (r.fault & ~fault_clear) | tmo_event;

      if (reached) begin
         nxt.tmo_arm = 1'b0;
         if (r.st == OSS_ON) begin
            nxt.tries = 3'h0;
         end
      end

      // Sequencer
      if (!run_ok) begin
         nxt.st      = OSS_OFF;
         nxt.tries   = 3'h0;
         nxt.tmo_arm = 1'b0;
      end else begin
         unique case (r.st)
            OSS_OFF:   launch = 1'b1;
            OSS_DELAY: begin
               if (tmr_exp[OSS_T_PHASE]) begin
                  nxt.st = OSS_RISE;
                  tmr_start[OSS_T_PHASE] = 1'b1;
                  tmr_load[OSS_T_PHASE]  = lin_ticks(r.cfg.ramp);
               end
            end
            OSS_RISE: begin
               if (tmr_exp[OSS_T_PHASE]) begin
                  nxt.st = OSS_ON;
               end
            end
            OSS_ON:    nxt.st = OSS_ON;
            OSS_FWAIT: begin
               if (tmr_exp[OSS_T_FWAIT]) begin
                  nxt.st = reached ? OSS_ON
                                   : retry_next(rty_code, r.tries);
               end
            end
            OSS_RWAIT: begin
               // Spacing timer was started with the previous attempt
               if (tmr_exp[OSS_T_RETRY]) begin
                  launch = 1'b1;
                  if (r.tries != 3'h7) begin
                     nxt.tries = r.tries + 3'h1;
                  end
               end
            end
            OSS_LATCH: begin
               if (fault_clear) begin
                  nxt.st = OSS_OFF;
               end
            end
            OSS_HOLD: begin
               if (!r.fault) begin
                  launch = 1'b1;
               end
            end
         endcase

         if (tmo_event) begin
            unique case (rsp_code)
               OSS_RSP_IGNORE:  nxt.tmo_arm = 1'b0;
               OSS_RSP_DELAY: begin
                  nxt.st = OSS_FWAIT;
                  nxt.tmo_arm = 1'b0;
                  tmr_start[OSS_T_FWAIT] = 1'b1;
                  tmr_load[OSS_T_FWAIT]  = unit_ticks;
               end
               OSS_RSP_DISABLE: begin
                  nxt.st = retry_next(rty_code, r.tries);
                  nxt.tmo_arm = 1'b0;
               end
               OSS_RSP_RESUME: begin
                  nxt.st = OSS_HOLD;
                  nxt.tmo_arm = 1'b0;
               end
            endcase
         end

         if (launch) begin
            nxt.st = OSS_DELAY;
            tmr_start = '1;
            tmr_start[OSS_T_FWAIT] = 1'b0;
            tmr_load[OSS_T_PHASE]  = lin_ticks(r.cfg.dly);
            tmr_load[OSS_T_TMO]    = lin_ticks(r.cfg.tmo_lim);
            tmr_load[OSS_T_RETRY]  = unit_ticks;
            nxt.tmo_arm = (r.cfg.tmo_lim != 16'h0000);
         end
      end

      nxt.out_en = (nxt.st == OSS_RISE) || (nxt.st == OSS_ON)
                   || (nxt.st == OSS_FWAIT);
      nxt.ramp   = (nxt.st == OSS_RISE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r     <= '0;
         r.cfg <= CFG_RST;
      end else begin
         r <= nxt;
      end
   end

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   assign cmd_rdata         = r.rdata;
   assign cmd_ack           = r.ack;
   assign cmd_nack          = r.nack;
   assign power_good_output = r.pg;
   assign output_enable     = r.out_en;
   assign ramp_active       = r.ramp;
   assign startup_fault     = r.fault;
   assign retry_count       = r.tries;
   assign seq_state         = r.st;

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_pg_on;
      (vout_meas >= r.cfg.pg_on && vout_meas > r.cfg.pg_off)
         |=> power_good_output;
   endproperty
   a_pg_on: assert property (p_pg_on)
      else $error("power-good not asserted above turn-on level");

   property p_pg_off;
      (vout_meas <= r.cfg.pg_off) |=> !power_good_output;
   endproperty
   a_pg_off: assert property (p_pg_off)
      else $error("power-good not deasserted at turn-off level");

   property p_pg_hold;
      (vout_meas > r.cfg.pg_off && vout_meas < r.cfg.pg_on)
         |=> $stable(power_good_output);
   endproperty
   a_pg_hold: assert property (p_pg_hold)
      else $error("power-good changed inside hysteresis band");

   property p_delay_quiet;
      (seq_state == OSS_DELAY) |-> (!output_enable && !ramp_active);
   endproperty
   a_delay_quiet: assert property (p_delay_quiet)
      else $error("output ramping during turn-on delay");

   property p_delay_to_rise;
      (seq_state == OSS_DELAY && tmr_exp[OSS_T_PHASE] && run_ok
       && !tmo_event) |=> (seq_state == OSS_RISE) ##0 ramp_active;
   endproperty
   a_delay_to_rise: assert property (p_delay_to_rise)
      else $error("ramp did not start after turn-on delay");

   property p_tmo;
      tmo_event |=> startup_fault;
   endproperty
   a_tmo: assert property (p_tmo)
      else $error("start-up timeout not flagged");

   property p_nolimit;
      (launch && r.cfg.tmo_lim == 16'h0000) |=> !r.tmo_arm;
   endproperty
   a_nolimit: assert property (p_nolimit)
      else $error("timeout armed with zero limit");

   property p_ignore;
      (tmo_event && rsp_code == OSS_RSP_IGNORE && seq_state == OSS_ON
       && !cmd.wr) |=> (seq_state == OSS_ON || !run_ok);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("ignored timeout interrupted operation");

   property p_fwait_on;
      (seq_state == OSS_FWAIT) |-> output_enable;
   endproperty
   a_fwait_on: assert property (p_fwait_on)
      else $error("output dropped during fault delay");

   property p_disable;
      (tmo_event && rsp_code == OSS_RSP_DISABLE) |=> !output_enable;
   endproperty
   a_disable: assert property (p_disable)
      else $error("output not disabled on timeout");

   property p_hold;
      (seq_state == OSS_HOLD && startup_fault && run_ok && !fault_clear)
         |=> !output_enable [*2];
   endproperty
   a_hold: assert property (p_hold)
      else $error("output enabled while fault present");

   property p_latch;
      (seq_state == OSS_LATCH && !fault_clear && run_ok)
         |=> (seq_state == OSS_LATCH) ##0 !output_enable;
   endproperty
   a_latch: assert property (p_latch)
      else $error("latched-off state left without clear");

   property p_forever;
      (tmo_event && rsp_code == OSS_RSP_DISABLE
       && rty_code == OSS_RTY_FOREVER) |=> (seq_state == OSS_RWAIT);
   endproperty
   a_forever: assert property (p_forever)
      else $error("continuous retry stopped");

   c_reach_on: cover property (seq_state == OSS_RISE
                               ##1 seq_state == OSS_ON);
   c_retry:    cover property (seq_state == OSS_RWAIT
                               ##1 seq_state == OSS_DELAY);
   c_latch:    cover property (seq_state == OSS_LATCH);
   c_hold:     cover property (seq_state == OSS_HOLD ##1 launch);

endmodule : oss_startup_seq

// file: inc/oss_pkg.sv
// Constants and types shared by the output start-up sequencer
package oss_pkg;

   // -------------------------------------------------------------
   // Command codes
   // -------------------------------------------------------------
   localparam logic [7:0]  OSS_CMD_PG_ON    = 8'h5E;
   localparam logic [7:0]  OSS_CMD_PG_OFF   = 8'h5F;
   localparam logic [7:0]  OSS_CMD_DELAY    = 8'h60;
   localparam logic [7:0]  OSS_CMD_RAMP     = 8'h61;
   localparam logic [7:0]  OSS_CMD_TMO_LIM  = 8'h62;
   localparam logic [7:0]  OSS_CMD_TMO_RSP  = 8'h63;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [15:0] OSS_RST_PG_ON    = 16'h0000;
   localparam logic [15:0] OSS_RST_PG_OFF   = 16'h0000;
   localparam logic [15:0] OSS_RST_DELAY    = 16'h0000;
   localparam logic [15:0] OSS_RST_RAMP     = 16'h0000;
   localparam logic [15:0] OSS_RST_TMO_LIM  = 16'h0000;
   localparam logic [7:0]  OSS_RST_TMO_RSP  = 8'h00;

   // -------------------------------------------------------------
   // Field layouts
   // -------------------------------------------------------------
   localparam int          OSS_RSP_HI       = 7;
   localparam int          OSS_RSP_LO       = 6;
   localparam int          OSS_RTY_HI       = 5;
   localparam int          OSS_RTY_LO       = 3;
   localparam int          OSS_TIME_HI      = 2;
   localparam int          OSS_TIME_LO      = 0;
   localparam int          OSS_LIN_EXP_HI   = 15;
   localparam int          OSS_LIN_EXP_LO   = 11;
   localparam int          OSS_LIN_MANT_HI  = 10;
   localparam logic [1:0]  OSS_RSP_IGNORE   = 2'h0;
   localparam logic [1:0]  OSS_RSP_DELAY    = 2'h1;
   localparam logic [1:0]  OSS_RSP_DISABLE  = 2'h2;
   localparam logic [1:0]  OSS_RSP_RESUME   = 2'h3;
   localparam logic [2:0]  OSS_RTY_NONE     = 3'h0;
   localparam logic [2:0]  OSS_RTY_FOREVER  = 3'h7;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int          OSS_CLK_HZ       = 20_000_000;
   localparam int          OSS_MS_PER_S     = 1000;
   localparam int          OSS_MS_CYC       = OSS_CLK_HZ / OSS_MS_PER_S;
   // Timers count sixteenths of a millisecond
   localparam logic [3:0]  OSS_TICK_SHIFT   = 4'h4;
   localparam int          OSS_TICKS_PER_MS = 16;
   localparam int          OSS_TMR_W        = 24;
   localparam int          OSS_PRE_W        = 16;
   localparam int          OSS_NUM_TMR      = 4;
   localparam int          OSS_T_PHASE      = 0;
   localparam int          OSS_T_TMO        = 1;
   localparam int          OSS_T_FWAIT      = 2;
   localparam int          OSS_T_RETRY      = 3;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      OSS_OFF   = 3'h0,
      OSS_DELAY = 3'h1,
      OSS_RISE  = 3'h3,
      OSS_ON    = 3'h2,
      OSS_FWAIT = 3'h6,
      OSS_RWAIT = 3'h7,
      OSS_LATCH = 3'h5,
      OSS_HOLD  = 3'h4
   } oss_state_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  code;
      logic [15:0] wdata;
   } oss_cmd_t;

   typedef struct packed {
      logic [15:0] pg_on;
      logic [15:0] pg_off;
      logic [15:0] dly;
      logic [15:0] ramp;
      logic [15:0] tmo_lim;
      logic [7:0]  rsp;
   } oss_cfg_t;

   typedef struct packed {
      logic [OSS_TMR_W-1:0] cnt;
      logic [OSS_PRE_W-1:0] pre;
      logic                 run;
      logic                 done;
   } oss_tmr_t;

endpackage : oss_pkg

// file: hdl/oss_tick_timer.sv
// One-shot timer counting sixteenths of a millisecond
`timescale 1ns/100ps
module oss_tick_timer #(
   parameter int TICK_DIV = oss_pkg::OSS_MS_CYC / oss_pkg::OSS_TICKS_PER_MS
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   // Control
   input  wire logic                           start,
   input  wire logic [oss_pkg::OSS_TMR_W-1:0]  load,
   // Status
   output logic                                expired
);
   import oss_pkg::*;

   localparam logic [OSS_PRE_W-1:0] PRE_LAST = OSS_PRE_W'(TICK_DIV - 1);
   localparam logic [OSS_TMR_W-1:0] CNT_ONE  = OSS_TMR_W'(1);

   oss_tmr_t r;
   oss_tmr_t nxt;

   always_comb begin
      nxt = r;
      if (start) begin
         // Zero load expires at once
         nxt.cnt  = load;
         nxt.pre  = '0;
         nxt.run  = (load != '0);
         nxt.done = (load == '0);
      end else if (r.run) begin
         if (r.pre == PRE_LAST) begin
            nxt.pre = '0;
            if (r.cnt == CNT_ONE) begin
               nxt.run  = 1'b0;
               nxt.done = 1'b1;
            end else begin
               nxt.cnt = r.cnt - CNT_ONE;
            end
         end else begin
            nxt.pre = r.pre + OSS_PRE_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign expired = r.done;

endmodule : oss_tick_timer

// file: verification/oss_plant.sv
// Behavioural output stage feeding back the measured voltage
`timescale 1ns/100ps
module oss_plant (
   // Clock, reset and drive
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        en,
   input  wire logic [15:0] target,
   // Measurement
   output logic [15:0]      vout
);
   // Collapses to zero whenever the stage is not driven
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) vout <= 16'h0000;
      else vout <= en ? target : 16'h0000;
   end
endmodule : oss_plant

// file: verification/output_startup_sequencer_tb.sv
// Self-checking bench of the output start-up sequencer
`timescale 1ns/100ps
module output_startup_sequencer_tb;
   import oss_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, fclr = 1'b0, opon = 1'b0;
   logic        cpin = 1'b1, ofl = 1'b0;
   localparam int MS = 32;
   oss_cmd_t    cmd = '0;
   logic [15:0] rdat, vout, tgt = 16'h0000, d;
   logic        ack, nack, pg, oen, ramp, sflt;
   logic [2:0]  rcnt;
   oss_state_t  st;
   int          err_total = 0, compares = 0, wcnt = 0;
   always #25 clk = ~clk;
   oss_plant plant (.clk(clk), .rst_n(rst_n), .en(oen), .target(tgt),
      .vout(vout));
   oss_startup_seq #(.MS_CYC(MS)) uut (.clk(clk), .rst_n(rst_n),
      .cmd(cmd), .cmd_rdata(rdat), .cmd_ack(ack), .cmd_nack(nack),
      .ctrl_pin(cpin), .bias_ok_pin(1'b1), .op_on(opon),
      .other_fault(ofl), .fault_clear(fclr), .vout_meas(vout),
      .uv_fault_limit(16'h4000), .vout_fault_unit_ms(8'h01),
      .power_good_output(pg), .output_enable(oen), .ramp_active(ramp),
      .startup_fault(sflt), .retry_count(rcnt), .seq_state(st));
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Readback after writing v to slot i: 0x63 keeps a byte, 0x64 is unknown
   function automatic logic [15:0] exp_rd(input int i,
                                          input logic [15:0] v);
      return (i == 6) ? 16'h0000 : (i == 5) ? (v & 16'h00FF) : v;
   endfunction : exp_rd
   task xfer(input logic w, input logic [7:0] c, input logic [15:0] v);
      @(posedge clk) cmd <= '{w, !w, c, v};
      @(posedge clk) cmd <= '0;
      #1;
   endtask : xfer
   // Clears any sticky fault and starts a fresh attempt
   task restart;
      @(posedge clk) begin opon <= 1'b0; fclr <= 1'b1; end
      repeat (2) @(posedge clk);
      opon <= 1'b1;
      fclr <= 1'b0;
   endtask : restart
   task wst(input oss_state_t s, input int n);
      int k;
      for (k = 0; k < n && st !== s; k++) @(posedge clk) #1;
      wcnt = k;
      chk("state", 16'(st), 16'(s));
   endtask : wst
   task end_sim;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   // Whole run needs well under 3000 cycles
   initial begin
      #1_000_000;
      err_total++;
      end_sim;
   end
   initial begin
      void'($urandom(32'h951C));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         d = 16'($urandom);
         xfer(1'b1, 8'h5E + 8'(i), d);
         chk("ack", {15'h0000, i < 6 ? ack : nack}, 16'h0001);
         xfer(1'b0, 8'h5E + 8'(i), 16'h0000);
         chk("rdata", rdat, exp_rd(i, d));
      end
      $display("registers done");
      xfer(1'b1, OSS_CMD_PG_ON, 16'h5000);
      xfer(1'b1, OSS_CMD_PG_OFF, 16'h3000);
      xfer(1'b1, OSS_CMD_DELAY, 16'h0002);
      xfer(1'b1, OSS_CMD_RAMP, 16'h0001);
      xfer(1'b1, OSS_CMD_TMO_LIM, 16'h0000);
      xfer(1'b1, OSS_CMD_TMO_RSP, 16'h0000);
      tgt <= 16'h6000;
      restart;
      wst(OSS_DELAY, 10);
      repeat (50) @(posedge clk) #1;
      chk("delay", {oen, 12'h000, st}, {1'b0, 12'h000, OSS_DELAY});
      wst(OSS_RISE, 30);
      chk("ramp", {15'h0000, ramp}, 16'h0001);
      wst(OSS_ON, 40);
      repeat (3) @(posedge clk) #1;
      chk("pg", {15'h0000, pg}, 16'h0001);
      tgt <= 16'h4000;
      repeat (3) @(posedge clk) #1;
      chk("pg", {15'h0000, pg}, 16'h0001);
      tgt <= 16'h2000;
      repeat (3) @(posedge clk) #1;
      chk("pg", {15'h0000, pg}, 16'h0000);
      tgt <= 16'h4000;
      repeat (90) @(posedge clk) #1;
      chk("pg", {15'h0000, pg}, 16'h0000);
      chk("nolimit", {15'h0000, sflt}, 16'h0000);
      $display("start-up done");
      xfer(1'b1, OSS_CMD_DELAY, 16'h0000);
      xfer(1'b1, OSS_CMD_RAMP, 16'h0000);
      xfer(1'b1, OSS_CMD_TMO_LIM, 16'h0001);
      tgt <= 16'h1000;
      restart;
      repeat (60) @(posedge clk) #1;
      chk("ignore", {sflt, 12'h000, st}, {1'b1, 12'h000, OSS_ON});
      xfer(1'b1, OSS_CMD_TMO_RSP, 16'h0089);
      restart;
      wst(OSS_RWAIT, 60);
      wst(OSS_DELAY, 100);
      // Two units of 1 ms start to start, less the 1 ms timeout
      chk("spacing", 16'(wcnt), 16'(2 * MS - MS));
      chk("retries", {13'h0000, rcnt}, 16'h0001);
      wst(OSS_LATCH, 100);
      chk("latched", {15'h0000, oen}, 16'h0000);
      xfer(1'b1, OSS_CMD_TMO_RSP, 16'h00A8);
      restart;
      wst(OSS_LATCH, 250);
      chk("retries", {13'h0000, rcnt}, 16'h0005);
      xfer(1'b1, OSS_CMD_TMO_RSP, 16'h00C0);
      restart;
      wst(OSS_HOLD, 60);
      @(posedge clk) fclr <= 1'b1;
      @(posedge clk) fclr <= 1'b0;
      wst(OSS_DELAY, 10);
      xfer(1'b1, OSS_CMD_TMO_RSP, 16'h0040);
      restart;
      wst(OSS_FWAIT, 60);
      chk("fwait", {15'h0000, oen}, 16'h0001);
      wst(OSS_LATCH, 60);
      // Endless retry, stopped here first by the pin, then by another fault
      xfer(1'b1, OSS_CMD_TMO_RSP, 16'h00B8);
      restart;
      for (int i = 0; i < 8; i++) begin
         wst(OSS_RWAIT, 60);
         wst(OSS_DELAY, 10);
      end
      @(posedge clk) cpin <= 1'b0;
      wst(OSS_OFF, 6);
      chk("retries", {13'h0000, rcnt}, 16'h0000);
      @(posedge clk) cpin <= 1'b1;
      wst(OSS_DELAY, 8);
      @(posedge clk) ofl <= 1'b1;
      wst(OSS_OFF, 3);
      @(posedge clk) ofl <= 1'b0;
      $display("fault responses done");
      end_sim;
   end
endmodule : output_startup_sequencer_tb
